// [pkg/dcd_consts.vh]
// constants for the drive condition detectors: offsets, codes, times
// assumes a 40 MHz core clock and byte addressed 32-bit register port
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH

`define DCD_CLK_PERIOD_PS 25000
`define DCD_MS_PS 1000000000
`define DCD_MS_CYCLES (`DCD_MS_PS / `DCD_CLK_PERIOD_PS)
`define DCD_MIN_ON_MS 16'h0064
`define DCD_LOSS_WIN_MS 16'h0190

`define DCD_PCT_RELEASE_CUR 10'h05A
`define DCD_PCT_LOSS 10'h00A
`define DCD_PCT_HYST_TRQ 10'h005
`define DCD_PCT_LOW_FREQ 10'h014
`define DCD_PCT_REC_LOW 10'h014
`define DCD_PCT_FULL 10'h064
`define DCD_RATIO_OFF 10'h3E7

`define DCD_FUNC_OVERLOAD 8'h07
`define DCD_FUNC_CMD_LOST 8'h21
`define DCD_FUNC_CUR_DET 8'h25
`define DCD_FUNC_LOW_TRQ 8'h2D

`define DCD_REG_CUR_LEVEL 8'h00
`define DCD_REG_CUR_TIMER 8'h04
`define DCD_REG_TRQ_LEVEL 8'h08
`define DCD_REG_TRQ_TIMER 8'h0C
`define DCD_REG_RATED_TRQ 8'h10
`define DCD_REG_LOSS_RATIO 8'h14
`define DCD_REG_BASE_FREQ 8'h18
`define DCD_REG_ENERGY_COEF 8'h1C
`define DCD_REG_TERM_FUNC 8'h20
`define DCD_REG_STATUS 8'h24
`define DCD_REG_ENERGY_ACC 8'h28
`define DCD_REG_ENERGY_DISP 8'h2C
`define DCD_REG_FREQ_CMD 8'h30

`define DCD_RST_CUR_LEVEL 16'h0000
`define DCD_RST_TIMER 16'h0000
`define DCD_RST_TRQ_LEVEL 10'h014
`define DCD_RST_RATED_TRQ 16'h0064
`define DCD_RST_LOSS_RATIO 10'h3E7
`define DCD_RST_BASE_FREQ 16'h0000
`define DCD_RST_ENERGY_COEF 16'h03E8
`define DCD_RST_TERM_FUNC 8'h07

`define DCD_ST_OVERLOAD 0
`define DCD_ST_CUR_DET 1
`define DCD_ST_LOW_TRQ 2
`define DCD_ST_CMD_LOST 3
`define DCD_ST_FALLBACK 4
`define DCD_ST_SUSPEND 5

`endif

// [sim/dcd_detectors_monitor.sv]
// checker for the drive condition detectors, top level ports only
// assumes settings change only through reg_wr, so a few are shadowed here
`timescale 1ns/1ps
`include "dcd_consts.vh"
module dcd_detectors_monitor #(
    parameter integer MS_CYCLES = 40000
) (
    input wire core_clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    input wire [15:0] cur_sample,
    input wire [15:0] cmd_raw,
    input wire drive_stopped,
    input wire overload_warning_q,
    input wire current_detected_q,
    input wire low_torque_q,
    input wire cmd_lost_q,
    input wire term_out_q,
    input wire [15:0] freq_cmd_q,
    input wire [31:0] energy_display_q
);
    localparam integer MIN_ON = 100 * MS_CYCLES;
    reg [15:0] lvl_q;
    reg [7:0] func_q;
    reg [15:0] coef_q;
    reg [31:0] cd_cnt_q;
    reg [31:0] lt_cnt_q;
    wire cur_over = cur_sample > lvl_q;
    wire cur_rel = {16'h0000, cur_sample} * 32'h64 < {16'h0000, lvl_q} * 32'h5A;
    wire term_sel = (func_q == `DCD_FUNC_OVERLOAD) ? overload_warning_q :
        (func_q == `DCD_FUNC_CMD_LOST) ? cmd_lost_q :
        (func_q == `DCD_FUNC_CUR_DET) ? current_detected_q :
        (func_q == `DCD_FUNC_LOW_TRQ) ? low_torque_q : 1'b0;
    // on-time is counted in cycles, so the 100 ms floor is checked exactly
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lvl_q <= `DCD_RST_CUR_LEVEL;
            func_q <= `DCD_RST_TERM_FUNC;
            coef_q <= `DCD_RST_ENERGY_COEF;
            cd_cnt_q <= 32'h0;
            lt_cnt_q <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `DCD_REG_CUR_LEVEL) lvl_q <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `DCD_REG_TERM_FUNC) func_q <= reg_wdata[7:0];
            if (reg_wr && reg_addr == `DCD_REG_ENERGY_COEF) coef_q <= reg_wdata[15:0];
            cd_cnt_q <= current_detected_q ? cd_cnt_q + 32'h1 : 32'h0;
            lt_cnt_q <= low_torque_q ? lt_cnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ovl_follow_a: assert property (overload_warning_q == $past(cur_over))
        else $error("overload warning does not follow current against level");
    cd_cause_a: assert property ($rose(current_detected_q) |-> $past(cur_over))
        else $error("current detected rose without current over level");
    cd_release_a: assert property ($fell(current_detected_q) |-> $past(cur_rel))
        else $error("current detected fell above the release level");
    cd_min_on_a: assert property ($fell(current_detected_q) |-> cd_cnt_q >= MIN_ON)
        else $error("current detected pulse shorter than minimum");
    lt_min_on_a: assert property ($fell(low_torque_q) && !$past(drive_stopped)
        && !$past(drive_stopped, 2) |-> lt_cnt_q >= MIN_ON)
        else $error("low torque pulse shorter than minimum");
    stop_clear_a: assert property (drive_stopped |=> !low_torque_q)
        else $error("low torque on while stopped");
    term_sel_a: assert property (term_out_q == $past(term_sel))
        else $error("terminal output does not follow selected function");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
        else $error("read data not zero outside read cycle");
    cmd_track_a: assert property ((!cmd_lost_q && $stable(cmd_raw)) [*3]
        |-> freq_cmd_q == cmd_raw)
        else $error("frequency command not following analog command");
    en_clear_a: assert property ((coef_q == 16'h0000) [*3] |-> energy_display_q == 32'h0)
        else $error("energy display not cleared with zero coefficient");
    cover property ($rose(current_detected_q));
    cover property ($rose(low_torque_q));
    cover property ($rose(cmd_lost_q));
    cover property ($fell(cmd_lost_q));
endmodule
bind dcd_detectors dcd_detectors_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .cur_sample(cur_sample), .cmd_raw(cmd_raw), .drive_stopped(drive_stopped),
    .overload_warning_q(overload_warning_q), .current_detected_q(current_detected_q),
    .low_torque_q(low_torque_q), .cmd_lost_q(cmd_lost_q), .term_out_q(term_out_q),
    .freq_cmd_q(freq_cmd_q), .energy_display_q(energy_display_q));

// [sim/dcd_detectors_tb.sv]
// bench for the drive condition detectors: bus tasks, plant model, pulses
// assumes a 4 cycle ms tick, so 100 ms is 400 cycles
`timescale 1ns/1ps
module dcd_detectors_tb;
    localparam integer MS = 4;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg wr_s = 1'b0;
    reg rd_s = 1'b0;
    reg kwh = 1'b0;
    reg stop_set = 1'b0;
    reg [15:0] cur_set = 16'h0, trq_set = 16'hFFFF, cmd_set = 16'h0, freq_set = 16'h0;
    reg [15:0] rnd = 16'h0017;
    reg [31:0] d;
    wire [31:0] rdata, edisp;
    wire [15:0] cur, trq, cmd, fout, fcmd;
    wire stp, ovl, cdet, ltq, lost, term;
    integer errors = 0, num_checks = 0, i, r, thr;
    reg [7:0] ra [0:6] = '{8'h08, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h00, 8'hFC};
    reg [31:0] rv [0:6] = '{32'h14, 32'h64, 32'h3E7, 32'h3E8, 32'h07, 32'h0, 32'h0};
    integer rat [0:3] = '{32'h32, 32'h3E7, 32'h0, 32'h96};
    always #12.5 core_clk = ~core_clk;
    dcd_detectors #(.MS_CYCLES(MS)) dut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata_q(rdata), .cur_sample(cur),
        .trq_sample(trq), .cmd_raw(cmd), .freq_out(fout), .drive_stopped(stp),
        .energy_kwh_pulse(kwh), .overload_warning_q(ovl), .current_detected_q(cdet),
        .low_torque_q(ltq), .cmd_lost_q(lost), .term_out_q(term), .freq_cmd_q(fcmd),
        .energy_display_q(edisp));
    dcd_plant_model plant (
        .core_clk(core_clk), .nrst(nrst), .cur_set(cur_set), .trq_set(trq_set),
        .cmd_set(cmd_set), .freq_set(freq_set), .stop_set(stop_set),
        .cur_sample_q(cur), .trq_sample_q(trq), .cmd_raw_q(cmd), .freq_out_q(fout),
        .drive_stopped_q(stp));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function fl(input integer w);
        fl = (w == 0) ? ovl : (w == 1) ? cdet : (w == 2) ? ltq : lost;
    endfunction
    task chkb(input string nm, input e, input g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task chkw(input string nm, input [31:0] e, input [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge core_clk);
        wr_s <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task ticks(input integer n);
        repeat (n * MS) @(posedge core_clk);
    endtask
    // bounded wait on a flag; the caller still compares, so a timeout shows
    task wt(input integer w, input v, input integer lim);
        integer k;
        for (k = 0; k < lim * MS && fl(w) !== v; k = k + 1) begin
            @(posedge core_clk);
            #1;
        end
    endtask
    task kw(input integer n);
        repeat (n) begin
            @(posedge core_clk);
            kwh <= 1'b1;
            @(posedge core_clk);
            kwh <= 1'b0;
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        errors = errors + 1;
        test_done;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            rd(ra[i]);
            chkw("reset value", rv[i], d);
        end
        wr(8'h04, 32'hFFFF);
        wr(8'h00, 32'h3E8);
        for (i = 0; i < 8; i = i + 1) begin
            rnd = lfsr(rnd);
            cur_set <= {5'h00, rnd[10:0]} + 16'h0100;
            ticks(1);
            chkb("overload", cur_set > 16'h03E8, ovl);
            chkb("term overload", cur_set > 16'h03E8, term);
        end
        cur_set <= 16'h0000;
        wr(8'h04, 32'h2);
        wr(8'h20, 32'h25);
        cur_set <= 16'h04B0;
        ticks(2);
        chkb("cur det early", 1'b0, cdet);
        wt(1, 1'b1, 4);
        chkb("cur det set", 1'b1, cdet);
        cur_set <= 16'h0320;
        ticks(98);
        chkb("cur det min on", 1'b1, cdet);
        chkb("term cur det", 1'b1, term);
        wt(1, 1'b0, 5);
        chkb("cur det clear", 1'b0, cdet);
        cur_set <= 16'h04B0;
        wt(1, 1'b1, 6);
        cur_set <= 16'h0384;
        ticks(110);
        chkb("cur det hyst", 1'b1, cdet);
        cur_set <= 16'h0383;
        wt(1, 1'b0, 3);
        chkb("cur det release", 1'b0, cdet);
        wr(8'h10, 32'hC8);
        wr(8'h0C, 32'h1);
        wr(8'h18, 32'h3E8);
        wr(8'h20, 32'h2D);
        chkb("low trq idle", 1'b0, ltq);
        freq_set <= 16'h01F4;
        trq_set <= 16'h001E;
        wt(2, 1'b1, 5);
        chkb("low trq set", 1'b1, ltq);
        trq_set <= 16'h0032;
        ticks(110);
        chkb("low trq hyst", 1'b1, ltq);
        chkb("term low trq", 1'b1, term);
        trq_set <= 16'h0033;
        wt(2, 1'b0, 3);
        chkb("low trq release", 1'b0, ltq);
        freq_set <= 16'h00C7;
        trq_set <= 16'h000A;
        ticks(10);
        chkb("low trq suspended", 1'b0, ltq);
        freq_set <= 16'h01F4;
        wt(2, 1'b1, 5);
        chkb("low trq resumed", 1'b1, ltq);
        stop_set <= 1'b1;
        ticks(1);
        chkb("low trq stopped", 1'b0, ltq);
        stop_set <= 1'b0;
        trq_set <= 16'h0064;
        wr(8'h20, 32'h21);
        for (i = 0; i < 4; i = i + 1) begin
            r = rat[i];
            wr(8'h14, r);
            cmd_set <= 16'h03E8;
            ticks(402);
            cmd_set <= 16'h0032;
            wt(3, 1'b1, 2);
            chkb("cmd lost", 1'b1, lost);
            chkw("fallback freq", (r == 999) ? 50 : 10 * r, {16'h0, fcmd});
            thr = (r == 0 || r == 999) ? 200 : (r >= 100) ? 1000 : 10 * r;
            cmd_set <= thr;
            ticks(3);
            chkb("still lost", 1'b1, lost);
            chkb("term cmd lost", 1'b1, term);
            cmd_set <= thr + 1;
            wt(3, 1'b0, 2);
            chkb("recovered", 1'b0, lost);
            ticks(1);
            chkw("cmd follow", thr + 1, {16'h0, fcmd});
        end
        kw(5);
        ticks(1);
        chkw("energy display", 32'h1388, edisp);
        rd(8'h28);
        chkw("energy acc", 32'h5, d);
        wr(8'h1C, 32'h0);
        kw(2);
        ticks(1);
        rd(8'h28);
        chkw("energy acc cleared", 32'h0, d);
        chkw("energy display cleared", 32'h0, edisp);
        wr(8'h1C, 32'h7D0);
        kw(3);
        ticks(1);
        chkw("energy display scaled", 32'h1770, edisp);
        test_done;
    end
endmodule

// [sim/dcd_plant_model.sv]
// plant model: power stage samples and analog frequency command source
// assumes the bench sets targets; values reach the design one edge later
`timescale 1ns/1ps
module dcd_plant_model (
    input wire core_clk,
    input wire nrst,
    input wire [15:0] cur_set,
    input wire [15:0] trq_set,
    input wire [15:0] cmd_set,
    input wire [15:0] freq_set,
    input wire stop_set,
    output reg [15:0] cur_sample_q,
    output reg [15:0] trq_sample_q,
    output reg [15:0] cmd_raw_q,
    output reg [15:0] freq_out_q,
    output reg drive_stopped_q
);
    // acts like a converter with one cycle latency; a drive in reset is stopped
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_sample_q <= 16'h0000;
            trq_sample_q <= 16'h0000;
            cmd_raw_q <= 16'h0000;
            freq_out_q <= 16'h0000;
            drive_stopped_q <= 1'b1;
        end else begin
            cur_sample_q <= cur_set;
            trq_sample_q <= trq_set;
            cmd_raw_q <= cmd_set;
            freq_out_q <= freq_set;
            drive_stopped_q <= stop_set;
        end
    end
endmodule

// [src/dcd_detectors.v]
// drive condition detectors: current, torque, command loss, energy display
// assumes samples and run state come from logic on core_clk, so no synchroniser
`timescale 1ns/1ps
`include "dcd_consts.vh"
module dcd_detectors #(
    parameter integer MS_CYCLES = `DCD_MS_CYCLES
) (
    input wire core_clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    input wire [15:0] cur_sample,
    input wire [15:0] trq_sample,
    input wire [15:0] cmd_raw,
    input wire [15:0] freq_out,
    input wire drive_stopped,
    input wire energy_kwh_pulse,
    output reg overload_warning_q,
    output reg current_detected_q,
    output reg low_torque_q,
    output reg cmd_lost_q,
    output reg term_out_q,
    output reg [15:0] freq_cmd_q,
    output reg [31:0] energy_display_q
);
    localparam CL_TRACK = 1'b0;
    localparam CL_LOST = 1'b1;

    // a * 100 compared with b * pct, without any division
    function pct_below;
        input [15:0] a;
        input [15:0] b;
        input [9:0] pct;
        reg [25:0] lhs;
        reg [25:0] rhs;
        begin
            lhs = {3'b000, a} * 26'h0000064;
            rhs = {10'h000, b} * {16'h0000, pct};
            pct_below = lhs < rhs;
        end
    endfunction

    function pct_above;
        input [15:0] a;
        input [15:0] b;
        input [9:0] pct;
        reg [25:0] lhs;
        reg [25:0] rhs;
        begin
            lhs = {3'b000, a} * 26'h0000064;
            rhs = {10'h000, b} * {16'h0000, pct};
            pct_above = lhs > rhs;
        end
    endfunction

    wire ms_tick;

    dcd_ms_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .nrst(nrst),
        .tick_q(ms_tick)
    );

    reg [15:0] current_level_setting_q;
    reg [15:0] current_timer_setting_q;
    reg [9:0] torque_level_setting_q;
    reg [15:0] torque_timer_setting_q;
    reg [15:0] rated_torque_q;
    reg [9:0] loss_fallback_ratio_q;
    reg [15:0] base_frequency_setting_q;
    reg [15:0] energy_display_coefficient_q;
    reg [7:0] term_func_q;
    reg [15:0] energy_acc_q;

    // register writes; a zero coefficient also wipes the accumulator
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            current_level_setting_q <= `DCD_RST_CUR_LEVEL;
            current_timer_setting_q <= `DCD_RST_TIMER;
            torque_level_setting_q <= `DCD_RST_TRQ_LEVEL;
            torque_timer_setting_q <= `DCD_RST_TIMER;
            rated_torque_q <= `DCD_RST_RATED_TRQ;
            loss_fallback_ratio_q <= `DCD_RST_LOSS_RATIO;
            base_frequency_setting_q <= `DCD_RST_BASE_FREQ;
            energy_display_coefficient_q <= `DCD_RST_ENERGY_COEF;
            term_func_q <= `DCD_RST_TERM_FUNC;
        end else if (reg_wr) begin
            if (reg_addr == `DCD_REG_CUR_LEVEL) begin
                current_level_setting_q <= reg_wdata[15:0];
            end else if (reg_addr == `DCD_REG_CUR_TIMER) begin
                current_timer_setting_q <= reg_wdata[15:0];
            end else if (reg_addr == `DCD_REG_TRQ_LEVEL) begin
                torque_level_setting_q <= reg_wdata[9:0];
            end else if (reg_addr == `DCD_REG_TRQ_TIMER) begin
                torque_timer_setting_q <= reg_wdata[15:0];
            end else if (reg_addr == `DCD_REG_RATED_TRQ) begin
                rated_torque_q <= reg_wdata[15:0];
            end else if (reg_addr == `DCD_REG_LOSS_RATIO) begin
                loss_fallback_ratio_q <= reg_wdata[9:0];
            end else if (reg_addr == `DCD_REG_BASE_FREQ) begin
                base_frequency_setting_q <= reg_wdata[15:0];
            end else if (reg_addr == `DCD_REG_ENERGY_COEF) begin
                energy_display_coefficient_q <= reg_wdata[15:0];
            end else if (reg_addr == `DCD_REG_TERM_FUNC) begin
                term_func_q <= reg_wdata[7:0];
            end
        end
    end

    // overload warning: plain level compare, no timer
    wire cur_over = cur_sample > current_level_setting_q;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            overload_warning_q <= 1'b0;
        end else begin
            overload_warning_q <= cur_over;
        end
    end

    // current detected with on delay, release hysteresis and minimum width
    reg [15:0] cur_dly_q;
    reg [15:0] cur_min_q;
    wire cur_release = pct_below(cur_sample, current_level_setting_q, `DCD_PCT_RELEASE_CUR);

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur_dly_q <= 16'h0000;
            cur_min_q <= 16'h0000;
            current_detected_q <= 1'b0;
        end else if (ms_tick) begin
            if (!current_detected_q) begin
                if (!cur_over) begin
                    cur_dly_q <= 16'h0000;
                end else if (cur_dly_q >= current_timer_setting_q) begin
                    current_detected_q <= 1'b1;
                    cur_min_q <= `DCD_MIN_ON_MS;
                    cur_dly_q <= 16'h0000;
                end else begin
                    cur_dly_q <= cur_dly_q + 16'h0001;
                end
            end else begin
                if (cur_min_q != 16'h0000) begin
                    cur_min_q <= cur_min_q - 16'h0001;
                end else if (cur_release) begin
                    current_detected_q <= 1'b0;
                end
            end
        end
    end

    // low torque: thresholds scaled against rated torque
    reg [15:0] trq_dly_q;
    reg [15:0] trq_min_q;
    wire [9:0] trq_off_pct = torque_level_setting_q + `DCD_PCT_HYST_TRQ;
    wire trq_under = pct_below(trq_sample, rated_torque_q, torque_level_setting_q);
    wire trq_over = pct_above(trq_sample, rated_torque_q, trq_off_pct);
    // torque estimate is poor at low speed, so the decision is frozen there
    wire trq_suspend = pct_below(freq_out, base_frequency_setting_q, `DCD_PCT_LOW_FREQ);

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trq_dly_q <= 16'h0000;
            trq_min_q <= 16'h0000;
            low_torque_q <= 1'b0;
        end else if (drive_stopped) begin
            trq_dly_q <= 16'h0000;
            trq_min_q <= 16'h0000;
            low_torque_q <= 1'b0;
        end else if (ms_tick && !trq_suspend) begin
            if (!low_torque_q) begin
                if (!trq_under) begin
                    trq_dly_q <= 16'h0000;
                end else if (trq_dly_q >= torque_timer_setting_q) begin
                    low_torque_q <= 1'b1;
                    trq_min_q <= `DCD_MIN_ON_MS;
                    trq_dly_q <= 16'h0000;
                end else begin
                    trq_dly_q <= trq_dly_q + 16'h0001;
                end
            end else begin
                if (trq_min_q != 16'h0000) begin
                    trq_min_q <= trq_min_q - 16'h0001;
                end else if (trq_over) begin
                    low_torque_q <= 1'b0;
                end
            end
        end
    end

    // command loss; works on the raw command, never the filtered one
    reg cl_state_q;
    reg [15:0] f1_q;
    reg [15:0] win_q;
    reg [9:0] rec_pct;
    reg [25:0] fallback_full;
    wire ratio_off = loss_fallback_ratio_q == `DCD_RATIO_OFF;
    wire cmd_low = pct_below(cmd_raw, f1_q, `DCD_PCT_LOSS);
    wire cmd_back = pct_above(cmd_raw, f1_q, rec_pct);

    always @* begin
        if (loss_fallback_ratio_q == 10'h000 || ratio_off) begin
            rec_pct = `DCD_PCT_REC_LOW;
        end else if (loss_fallback_ratio_q >= `DCD_PCT_FULL) begin
            rec_pct = `DCD_PCT_FULL;
        end else begin
            rec_pct = loss_fallback_ratio_q;
        end
        fallback_full = ({10'h000, f1_q} * {16'h0000, loss_fallback_ratio_q}) / 26'h0000064;
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cl_state_q <= CL_TRACK;
            f1_q <= 16'h0000;
            win_q <= 16'h0000;
        end else begin
            case (cl_state_q)
                CL_TRACK: begin
                    if (cmd_low) begin
                        cl_state_q <= CL_LOST;
                    end else if (ms_tick) begin
                        // reference is refreshed once per window
                        if (win_q >= `DCD_LOSS_WIN_MS - 16'h0001) begin
                            win_q <= 16'h0000;
                            f1_q <= cmd_raw;
                        end else begin
                            win_q <= win_q + 16'h0001;
                        end
                    end
                end
                CL_LOST: begin
                    if (cmd_back) begin
                        cl_state_q <= CL_TRACK;
                        win_q <= 16'h0000;
                        f1_q <= cmd_raw;
                    end
                end
                default: begin
                    cl_state_q <= CL_TRACK;
                end
            endcase
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_lost_q <= 1'b0;
            freq_cmd_q <= 16'h0000;
        end else begin
            cmd_lost_q <= cl_state_q == CL_LOST;
            if (cl_state_q == CL_LOST && !ratio_off) begin
                freq_cmd_q <= fallback_full[15:0];
            end else begin
                freq_cmd_q <= cmd_raw;
            end
        end
    end

    // energy accumulator saturates instead of wrapping
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            energy_acc_q <= 16'h0000;
            energy_display_q <= 32'h00000000;
        end else begin
            if (energy_display_coefficient_q == 16'h0000) begin
                energy_acc_q <= 16'h0000;
            end else if (energy_kwh_pulse && energy_acc_q != 16'hFFFF) begin
                energy_acc_q <= energy_acc_q + 16'h0001;
            end
            energy_display_q <= energy_display_coefficient_q * energy_acc_q;
        end
    end

    // one general purpose terminal, steered by its function code
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            term_out_q <= 1'b0;
        end else if (term_func_q == `DCD_FUNC_OVERLOAD) begin
            term_out_q <= overload_warning_q;
        end else if (term_func_q == `DCD_FUNC_CUR_DET) begin
            term_out_q <= current_detected_q;
        end else if (term_func_q == `DCD_FUNC_LOW_TRQ) begin
            term_out_q <= low_torque_q;
        end else if (term_func_q == `DCD_FUNC_CMD_LOST) begin
            term_out_q <= cmd_lost_q;
        end else begin
            term_out_q <= 1'b0;
        end
    end

    // read port, data one cycle after the strobe; unmapped reads zero
    reg [31:0] status_w;

    always @* begin
        status_w = 32'h00000000;
        status_w[`DCD_ST_OVERLOAD] = overload_warning_q;
        status_w[`DCD_ST_CUR_DET] = current_detected_q;
        status_w[`DCD_ST_LOW_TRQ] = low_torque_q;
        status_w[`DCD_ST_CMD_LOST] = cmd_lost_q;
        status_w[`DCD_ST_FALLBACK] = cmd_lost_q && !ratio_off;
        status_w[`DCD_ST_SUSPEND] = trq_suspend;
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `DCD_REG_CUR_LEVEL) begin
                reg_rdata_q <= {16'h0000, current_level_setting_q};
            end else if (reg_addr == `DCD_REG_CUR_TIMER) begin
                reg_rdata_q <= {16'h0000, current_timer_setting_q};
            end else if (reg_addr == `DCD_REG_TRQ_LEVEL) begin
                reg_rdata_q <= {22'h000000, torque_level_setting_q};
            end else if (reg_addr == `DCD_REG_TRQ_TIMER) begin
                reg_rdata_q <= {16'h0000, torque_timer_setting_q};
            end else if (reg_addr == `DCD_REG_RATED_TRQ) begin
                reg_rdata_q <= {16'h0000, rated_torque_q};
            end else if (reg_addr == `DCD_REG_LOSS_RATIO) begin
                reg_rdata_q <= {22'h000000, loss_fallback_ratio_q};
            end else if (reg_addr == `DCD_REG_BASE_FREQ) begin
                reg_rdata_q <= {16'h0000, base_frequency_setting_q};
            end else if (reg_addr == `DCD_REG_ENERGY_COEF) begin
                reg_rdata_q <= {16'h0000, energy_display_coefficient_q};
            end else if (reg_addr == `DCD_REG_TERM_FUNC) begin
                reg_rdata_q <= {24'h000000, term_func_q};
            end else if (reg_addr == `DCD_REG_STATUS) begin
                reg_rdata_q <= status_w;
            end else if (reg_addr == `DCD_REG_ENERGY_ACC) begin
                reg_rdata_q <= {16'h0000, energy_acc_q};
            end else if (reg_addr == `DCD_REG_ENERGY_DISP) begin
                reg_rdata_q <= energy_display_q;
            end else if (reg_addr == `DCD_REG_FREQ_CMD) begin
                reg_rdata_q <= {16'h0000, freq_cmd_q};
            end else begin
                reg_rdata_q <= 32'h00000000;
            end
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end
endmodule

// [src/dcd_ms_tick.v]
// millisecond timebase for the detectors
// assumes one free running core clock; tick is a one cycle pulse
`timescale 1ns/1ps
module dcd_ms_tick #(
    parameter integer MS_CYCLES = 40000
) (
    input wire core_clk,
    input wire nrst,
    output reg tick_q
);
    reg [31:0] cnt_q;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (cnt_q >= MS_CYCLES - 1) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end
endmodule
